// *** ahbw_params.svh ***
/*
 holds the constants of the host bus width port: widths, addresses, mode value.
 assumes inclusion by the package and the design modules.
*/
`ifndef AHBW_PARAMS_SVH
`define AHBW_PARAMS_SVH

// ---------------------------------------------------------------
// bus geometry
// ---------------------------------------------------------------
`define AHBW_WORD_W      28
`define AHBW_HALF_W      16
`define AHBW_ADDR_W      4
`define AHBW_IGNORE_W    4

// ---------------------------------------------------------------
// bus width switch
// ---------------------------------------------------------------
`define AHBW_WIDTH_ADDR  4'hE
`define AHBW_WIDTH_VALUE 28'h0000010

`endif

// *** ahbw_pkg.sv ***
/*
 holds the types of the host bus width port.
 assumes ahbw_params.svh is on the include path.
*/
`include "ahbw_params.svh"

package ahbw_pkg;
   typedef enum logic [1:0]
   {
      AHBW_IDLE  = 2'b00,
      AHBW_FIRST = 2'b01,
      AHBW_ACC   = 2'b11
   } ahbw_acc_t;

   typedef logic [`AHBW_WORD_W-1:0] ahbw_word_t;
endpackage

// *** ahbw_half_if.sv ***
/*
 holds the interface between the port top and its half-word pairing unit.
 assumes one clock domain shared by both ends.
*/
`timescale 1ns/10ps

interface ahbw_half_if;
   import ahbw_pkg::*;
   logic       strobe_end;
   logic       wide_mode;
   logic       clear;
   logic       second;
   ahbw_word_t wr_word;
   logic [15:0] wr_half;
   logic       wr_first_end;
   modport top  (output strobe_end, output wide_mode, output clear, output wr_half, output wr_first_end,
                 input second, input wr_word);
   modport pair (input strobe_end, input wide_mode, input clear, input wr_half, input wr_first_end,
                 output second, output wr_word);
endinterface

// *** ahbw_pair.sv ***
/*
 holds the half-word pairing unit: tracks first/second access and joins write halves.
 assumes strobes are already reduced to one-cycle end pulses by the top.
*/
`timescale 1ns/10ps

`include "ahbw_params.svh"

module ahbw_pair
   import ahbw_pkg::*;
(
   // clock and reset
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic ce,
   // link to top
   ahbw_half_if.pair hp
);
   typedef struct packed
   {
      logic       second;
      logic [15:0] low;
   } ahbw_pair_state_t;

   ahbw_pair_state_t st;
   ahbw_pair_state_t next_st;

   // ---------------------------------------------------------------
   // pairing
   // ---------------------------------------------------------------
   always_comb
   begin
      next_st = st;
      if (hp.clear || hp.wide_mode)
      begin
         next_st.second = 1'b0;
      end
      else if (hp.strobe_end)
      begin
         next_st.second = ~st.second;
      end
      if (hp.wr_first_end && !st.second)
      begin
         next_st.low = hp.wr_half;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         st <= '0;
      end
      else if (ce)
      begin
         st <= next_st;
      end
   end

   assign hp.second  = st.second;
   // top 4 bits of the high half are dropped on writes
   assign hp.wr_word = {hp.wr_half[`AHBW_HALF_W-`AHBW_IGNORE_W-1:0], st.low};
endmodule

// *** ahbw_port.sv ***
/*
 holds the top of the host bus width port: strobe sampling, output drive,
 28/16-bit mode switch and the write/read word paths.
 assumes host pins synchronous to clk; core supplies read words and empty flags.
*/
`timescale 1ns/10ps

`include "ahbw_params.svh"

module ahbw_port
   import ahbw_pkg::*;
#(
   parameter int WORD_W = `AHBW_WORD_W,
   parameter int ADDR_W = `AHBW_ADDR_W
)
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              nrst,
   input  wire logic              ce,
   // host pins
   input  wire logic              chip_select_low,
   input  wire logic              read_strobe_low,
   input  wire logic              write_strobe_low,
   input  wire logic              output_drive_enable_n,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [WORD_W-1:0] data_in,
   output logic      [WORD_W-1:0] data_out,
   output logic                   data_oe,
   // core side
   input  wire logic [WORD_W-1:0] core_rd_data,
   input  wire logic              core_fifo_one_empty,
   input  wire logic              core_fifo_two_empty,
   output logic                   rd_pulse,
   output logic      [ADDR_W-1:0] rd_addr,
   output logic                   wr_pulse,
   output logic      [ADDR_W-1:0] wr_addr,
   output logic      [WORD_W-1:0] wr_data,
   output logic                   half_mode,
   output logic                   fifo_one_empty_flag,
   output logic                   fifo_two_empty_flag
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed
   {
      ahbw_acc_t        rd_st;
      ahbw_acc_t        wr_st;
      logic             half;
      logic [WORD_W-1:0] rd_word;
      logic [WORD_W-1:0] dout;
      logic             oe;
      logic             rdp;
      logic             wrp;
      logic [ADDR_W-1:0] ra;
      logic [ADDR_W-1:0] wa;
      logic [WORD_W-1:0] wd;
      logic             empty_one;
      logic             empty_two;
   } ahbw_state_t;

   ahbw_state_t st;
   ahbw_state_t next_st;
   ahbw_half_if hp ();

   logic rd_act;
   logic wr_act;
   logic rd_end;
   logic wr_end;

   // ---------------------------------------------------------------
   // decode functions
   // ---------------------------------------------------------------
   // one tracker per strobe: idle, first low edge, held low
   function automatic ahbw_acc_t step_acc(input ahbw_acc_t cur, input logic act);
      ahbw_acc_t nxt;
      nxt = AHBW_IDLE;
      case (cur)
         AHBW_IDLE:  nxt = act ? AHBW_FIRST : AHBW_IDLE;
         AHBW_FIRST: nxt = act ? AHBW_ACC : AHBW_IDLE;
         AHBW_ACC:   nxt = act ? AHBW_ACC : AHBW_IDLE;
         default:    nxt = AHBW_IDLE;
      endcase
      return nxt;
   endfunction

   // whole-word write that selects the paired 16-bit bus
   function automatic logic is_width_switch(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
      logic hit;
      hit = 1'b0;
      if (a == `AHBW_WIDTH_ADDR && d == `AHBW_WIDTH_VALUE)
      begin
         hit = 1'b1;
      end
      return hit;
   endfunction

   // ---------------------------------------------------------------
   // strobe decode
   // ---------------------------------------------------------------
   assign rd_act = !chip_select_low && !read_strobe_low;
   assign wr_act = !chip_select_low && !write_strobe_low;
   assign rd_end = (st.rd_st != AHBW_IDLE) && !rd_act;
   assign wr_end = (st.wr_st != AHBW_IDLE) && !wr_act;

   assign hp.strobe_end   = rd_end || wr_end;
   assign hp.wide_mode    = !st.half;
   assign hp.clear        = 1'b0;
   assign hp.wr_half      = data_in[`AHBW_HALF_W-1:0];
   assign hp.wr_first_end = wr_end;

   // ---------------------------------------------------------------
   // pairing unit
   // ---------------------------------------------------------------
   ahbw_pair u_pair
   (
      .clk  (clk),
      .nrst (nrst),
      .ce   (ce),
      .hp   (hp)
   );

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb
   begin
      next_st     = st;
      next_st.rdp = 1'b0;
      next_st.wrp = 1'b0;
      next_st.empty_one = core_fifo_one_empty;
      next_st.empty_two = core_fifo_two_empty;
      next_st.rd_st = step_acc(st.rd_st, rd_act);
      next_st.wr_st = step_acc(st.wr_st, wr_act);
      // read: fetch word from core on the first half (or whole word)
      if (rd_act && st.rd_st == AHBW_IDLE)
      begin
         next_st.ra = addr;
         if (!st.half || !hp.second)
         begin
            next_st.rdp     = 1'b1;
            next_st.rd_word = core_rd_data;
         end
      end
      // returned value: low half first, high half second
      if (!st.half)
      begin
         next_st.dout = st.rd_word;
      end
      else if (!hp.second)
      begin
         next_st.dout = {{(WORD_W-`AHBW_HALF_W){1'b0}}, st.rd_word[`AHBW_HALF_W-1:0]};
      end
      else
      begin
         next_st.dout = {{`AHBW_HALF_W{1'b0}}, st.rd_word[WORD_W-1:`AHBW_HALF_W]};
      end
      // drive: always with oe low, only during a read strobe with oe high
      next_st.oe = !output_drive_enable_n || rd_act;
      // write: whole word, or on the second half
      if (wr_end)
      begin
         if (!st.half)
         begin
            next_st.wrp = 1'b1;
            next_st.wa  = st.wa;
            next_st.wd  = data_in;
         end
         else if (hp.second)
         begin
            next_st.wrp = 1'b1;
            next_st.wd  = hp.wr_word;
         end
      end
      if (wr_act && st.wr_st == AHBW_IDLE)
      begin
         next_st.wa = addr;
      end
      // width switch on a completed whole-word write
      if (wr_end && !st.half && is_width_switch(st.wa, data_in))
      begin
         next_st.half = 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         st <= '0;
      end
      else if (ce)
      begin
         st <= next_st;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign data_out            = st.dout;
   assign data_oe             = st.oe;
   assign rd_pulse            = st.rdp;
   assign rd_addr             = st.ra;
   assign wr_pulse            = st.wrp;
   assign wr_addr             = st.wa;
   assign wr_data             = st.wd;
   assign half_mode           = st.half;
   assign fifo_one_empty_flag = st.empty_one;
   assign fifo_two_empty_flag = st.empty_two;
endmodule

// *** ahbw_core_model.sv ***
/*
 holds a core-side model: one result fifo feeding the port.
 assumes rd_pulse comes once per word from the port.
*/
`timescale 1ns/10ps
module ahbw_core_model
   import ahbw_pkg::*;
#(
   parameter int DEPTH = 3
)
(
   // clock and reset
   input  wire logic clk,
   input  wire logic nrst,
   // core side
   input  wire logic rd_pulse,
   output ahbw_word_t rd_data,
   output logic       one_empty,
   output logic       two_empty
);
   logic [7:0] taken;
   always_ff @(posedge clk)
      if (!nrst)
         taken <= 8'h00;
      else if (rd_pulse)
         taken <= taken + 8'h01;
   assign rd_data   = 28'hA5C3E10 + {20'h00000, taken};
   assign one_empty = (taken >= 8'(DEPTH));
   assign two_empty = 1'b1;
endmodule

// *** ahbw_port_checker.sv ***
/*
 holds assertions on the port top.
 assumes bind onto ahbw_port, one clock.
*/
`timescale 1ns/10ps
`include "ahbw_params.svh"
module ahbw_port_checker
#(
   parameter int WORD_W = 28,
   parameter int ADDR_W = 4
)
(
   // clock and reset
   input wire logic              clk,
   input wire logic              nrst,
   // host pins
   input wire logic              chip_select_low,
   input wire logic              read_strobe_low,
   input wire logic              write_strobe_low,
   input wire logic              output_drive_enable_n,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic              data_oe,
   // core side
   input wire logic              rd_pulse,
   input wire logic [ADDR_W-1:0] rd_addr,
   input wire logic              wr_pulse,
   input wire logic [ADDR_W-1:0] wr_addr,
   input wire logic [WORD_W-1:0] wr_data,
   input wire logic              half_mode
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   a_rd_once_only: assert property (rd_pulse |=> !rd_pulse) else $error("read pulse too long");
   a_oe_perm_drive: assert property ((nrst && !output_drive_enable_n) ##1 !output_drive_enable_n
      |-> data_oe) else $error("bus not driven");
   a_oe_strobe_only: assert property ((output_drive_enable_n && read_strobe_low) [*2] |-> !data_oe)
      else $error("bus driven idle");
   a_rd_drive_bus: assert property (!chip_select_low && !read_strobe_low |=> data_oe)
      else $error("read not driven");
   a_rd_start_pulse: assert property (!half_mode && !(chip_select_low || read_strobe_low)
      && $past(chip_select_low || read_strobe_low) |=> rd_pulse) else $error("read missed");
   a_rd_addr_hold: assert property (rd_pulse |-> rd_addr == $past(addr)) else $error("read addr");
   a_wr_end_pulse: assert property (!half_mode && write_strobe_low
      && $past(!write_strobe_low && !chip_select_low) |=> wr_pulse) else $error("write missed");
   a_mode_sticky: assert property (half_mode |=> half_mode) else $error("mode lost");
   a_wide_default: assert property ($rose(half_mode) |-> wr_pulse && wr_addr == `AHBW_WIDTH_ADDR
      && wr_data == `AHBW_WIDTH_VALUE) else $error("mode without switch");
   a_switch_mode: assert property (wr_pulse && wr_addr == `AHBW_WIDTH_ADDR
      && wr_data == `AHBW_WIDTH_VALUE |-> half_mode) else $error("switch ignored");
   c_half_read: cover property (rd_pulse && half_mode);
   c_write: cover property (wr_pulse);
   c_switch: cover property ($rose(half_mode));
endmodule
bind ahbw_port ahbw_port_checker #(.WORD_W(WORD_W), .ADDR_W(ADDR_W)) u_chk (.clk(clk), .nrst(nrst),
   .chip_select_low(chip_select_low), .read_strobe_low(read_strobe_low), .write_strobe_low(write_strobe_low),
   .output_drive_enable_n(output_drive_enable_n), .addr(addr), .data_oe(data_oe), .rd_pulse(rd_pulse),
   .rd_addr(rd_addr), .wr_pulse(wr_pulse), .wr_addr(wr_addr), .wr_data(wr_data), .half_mode(half_mode));

// *** ahbw_port_bench.sv ***
/*
 holds the self-checking bench of the port.
 assumes the core model stands on the core side.
*/
`timescale 1ns/10ps
`include "ahbw_params.svh"
module ahbw_port_bench;
   import ahbw_pkg::*;
   logic       clk, nrst, cs_n, rd_n, wr_n, oe_n, data_oe, rd_pulse, wr_pulse, half_mode;
   logic       e1, e2, fe1, fe2, p_rd, p_wr, oe_on, oe_off;
   logic [3:0] addr, rd_addr, wr_addr;
   ahbw_word_t din, dout, core_word, wr_data, q;
   int         failures, checked, cycles;
   ahbw_port u_dut (.clk(clk), .nrst(nrst), .ce(1'b1), .chip_select_low(cs_n), .read_strobe_low(rd_n),
      .write_strobe_low(wr_n), .output_drive_enable_n(oe_n), .addr(addr), .data_in(din), .data_out(dout),
      .data_oe(data_oe), .core_rd_data(core_word), .core_fifo_one_empty(e1), .core_fifo_two_empty(e2),
      .rd_pulse(rd_pulse), .rd_addr(rd_addr), .wr_pulse(wr_pulse), .wr_addr(wr_addr), .wr_data(wr_data),
      .half_mode(half_mode), .fifo_one_empty_flag(fe1), .fifo_two_empty_flag(fe2));
   ahbw_core_model u_core (.clk(clk), .nrst(nrst), .rd_pulse(rd_pulse), .rd_data(core_word),
      .one_empty(e1), .two_empty(e2));
   task chk(input ahbw_word_t got, input ahbw_word_t exp);
      checked++;
      if (got !== exp)
      begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task final_report;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // one whole access, strobes released after three low edges
   task acc(input logic wr, input logic [3:0] a, input ahbw_word_t d);
      @(posedge clk);
      cs_n <= 1'b0;
      addr <= a;
      din  <= d;
      if (wr)
         wr_n <= 1'b0;
      else
         rd_n <= 1'b0;
      @(posedge clk);
      #1 p_rd = rd_pulse;
      repeat (2) @(posedge clk);
      cs_n <= 1'b1;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      #1 oe_on = data_oe;
      q = dout;
      @(posedge clk);
      #1 p_wr = wr_pulse;
      @(posedge clk);
      #1 oe_off = data_oe;
   endtask
   task t_wide;
      chk(data_oe, 1);
      @(posedge clk);
      oe_n <= 1'b1;
      repeat (2) @(posedge clk);
      #1 chk(data_oe, 0);
      @(posedge clk);
      rd_n <= 1'b0;
      @(posedge clk);
      #1 chk(rd_pulse, 0);
      chk(data_oe, 0);
      @(posedge clk);
      rd_n <= 1'b1;
      acc(0, 4'h1, 28'h0000000);
      chk(p_rd, 1);
      chk(rd_addr, 4'h1);
      chk(oe_on, 1);
      chk(q, 28'hA5C3E10);
      chk(oe_off, 0);
      acc(1, 4'h3, 28'hFEDCBA9);
      chk(oe_on, 0);
      chk(p_wr, 1);
      chk(wr_data, 28'hFEDCBA9);
      chk(half_mode, 0);
      chk(fe2, 1);
      $display("wide test done");
   endtask
   task t_half;
      acc(1, `AHBW_WIDTH_ADDR, `AHBW_WIDTH_VALUE);
      chk(half_mode, 1);
      acc(1, 4'h5, 28'h0001234);
      chk(p_wr, 0);
      acc(1, 4'h5, 28'h000F987);
      chk(p_wr, 1);
      chk(wr_data, 28'h9871234);
      chk(wr_addr, 4'h5);
      acc(0, 4'h2, 28'h0000000);
      chk(q[15:0], 28'h0003E11);
      chk(rd_addr, 4'h2);
      acc(0, 4'h2, 28'h0000000);
      chk(p_rd, 0);
      chk(q[11:0], 28'h0000A5C);
      chk(fe1, 0);
      acc(0, 4'h2, 28'h0000000);
      chk(fe1, 1);
      acc(0, 4'h2, 28'h0000000);
      chk(q[11:0], 28'h0000A5C);
      $display("half test done");
   endtask
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         failures++;
         final_report;
      end
   end
   initial
   begin
      {nrst, cs_n, rd_n, wr_n, oe_n, addr, din} = {5'b01110, 4'h0, 28'h0000000};
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      repeat (2) @(posedge clk);
      #1 t_wide;
      t_half;
      final_report;
   end
endmodule
